/* File: pkg/clkgen_ctrl_pkg.sv */
// constants and types for the strap latch and output gating block
package clkgen_ctrl_pkg;
  localparam int num_diff_outputs = 4;
  localparam int num_ref_outputs = 2;
  localparam int gate_code_width = 2;
  // power-up settle time before the strap is sampled, in ns
  localparam int strap_settle_ns = 40;
  localparam int clock_period_ns = 4;
  localparam int strap_settle_cycles = (strap_settle_ns + clock_period_ns - 1) / clock_period_ns;
  localparam logic [7:0] settle_count_reset = 8'h00;
  // strap value meanings
  localparam logic strap_sel_pins = 1'b1;
  localparam logic strap_serial_bus = 1'b0;
  localparam logic strap_reset = 1'b0;
  // pin pull levels when undriven
  localparam logic select_pull_level = 1'b0;
  localparam logic gate_pull_level = 1'b1;
  localparam logic [3:0] diff_enable_reset = 4'h0;
  localparam logic [1:0] ref_enable_reset = 2'h0;
  typedef enum logic [1:0] {pu_settle, pu_latch, pu_run} powerup_state_t;
endpackage

/* File: rtl/diff_gate_map.sv */
// decoder from the two-bit enable code to the differential output gates
`timescale 1ns/1ps
`default_nettype none
module diff_gate_map
  import clkgen_ctrl_pkg::*;
(
  input wire logic [clkgen_ctrl_pkg::gate_code_width-1:0] gate_code,
  output logic [clkgen_ctrl_pkg::num_diff_outputs-1:0] pin_enable
);
  // thermometer map; code 10 runs three pairs, 11 all four
  always_comb begin
    unique case (gate_code)
      2'h0: pin_enable = 4'h1;
      2'h1: pin_enable = 4'h3;
      2'h2: pin_enable = 4'h7;
      2'h3: pin_enable = 4'hf;
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/strap_latch_output_gating.sv */
// power-up strap latch, shared pin steering and output gating
`timescale 1ns/1ps
`default_nettype none
module strap_latch_output_gating
  import clkgen_ctrl_pkg::*;
#(
  parameter int settle_cycles = strap_settle_cycles
)(
  input wire logic clock,
  input wire logic arst_n,
  // mode strap pin, four-signal form
  input wire logic ref_zero_mode_strap_in,
  input wire logic ref_zero_mode_strap_driven,
  output logic ref_zero_mode_strap_out,
  output logic ref_zero_mode_strap_oe,
  // shared pins: select bits or serial bus
  input wire logic cfg_select_bit_zero_in,
  input wire logic cfg_select_bit_zero_driven,
  input wire logic cfg_select_bit_one_in,
  input wire logic cfg_select_bit_one_driven,
  input wire logic serial_data_drive_low,
  output logic cfg_select_bit_one_out,
  output logic cfg_select_bit_one_oe,
  // enable pins with pull-ups
  input wire logic output_gate_low_bit,
  input wire logic output_gate_low_bit_driven,
  input wire logic output_gate_high_bit,
  input wire logic output_gate_high_bit_driven,
  // stored configuration enables
  input wire logic [clkgen_ctrl_pkg::num_diff_outputs-1:0] stored_diff_enable,
  input wire logic [clkgen_ctrl_pkg::num_ref_outputs-1:0] stored_ref_enable,
  input wire logic ref_clock_zero_src,
  // results
  output logic strap_valid,
  output logic strap_value,
  output logic [1:0] cfg_select,
  output logic serial_clock_line,
  output logic serial_data_line,
  output logic [clkgen_ctrl_pkg::num_diff_outputs-1:0] diff_clock_run,
  output logic ref_clock_zero_run,
  output logic ref_clock_one_run
);
  import clkgen_ctrl_pkg::*;

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;
  powerup_state_t state_reg;
  logic [7:0] settle_reg;
  logic strap_reg;
  logic strap_pin;
  logic cfg_select_bit_zero_pin;
  logic cfg_select_bit_one_pin;
  logic [1:0] gate_code;
  logic [num_diff_outputs-1:0] gate_map;
  logic [num_diff_outputs-1:0] diff_run_reg;
  logic [num_ref_outputs-1:0] ref_run_reg;
  logic [1:0] cfg_select_reg;
  logic scl_reg;
  logic sda_reg;

  // reset release through two flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // pin levels with pulls applied
  assign strap_pin = ref_zero_mode_strap_driven ? ref_zero_mode_strap_in : select_pull_level;
  assign cfg_select_bit_zero_pin = cfg_select_bit_zero_driven ? cfg_select_bit_zero_in : select_pull_level;
  assign cfg_select_bit_one_pin = cfg_select_bit_one_driven ? cfg_select_bit_one_in : select_pull_level;
  assign gate_code[0] = output_gate_low_bit_driven ? output_gate_low_bit : gate_pull_level;
  assign gate_code[1] = output_gate_high_bit_driven ? output_gate_high_bit : gate_pull_level;

  // power-up sequence: settle, latch once, then run forever
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pu_settle;
      settle_reg <= settle_count_reset;
    end else begin
      unique case (state_reg)
        pu_settle: begin
          if (settle_reg == 8'(settle_cycles - 1)) begin
            state_reg <= pu_latch;
          end else begin
            settle_reg <= settle_reg + 8'h01;
          end
        end
        pu_latch: state_reg <= pu_run;
        pu_run: state_reg <= pu_run;
        default: state_reg <= pu_settle;
      endcase
    end
  end

  // strap caught only in the latch state; later pin changes ignored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_reg <= strap_reset;
    end else if (state_reg == pu_latch) begin
      strap_reg <= strap_pin;
    end
  end

  // strap pin turns into the reference output after latching
  assign ref_zero_mode_strap_oe = (state_reg == pu_run);
  assign ref_zero_mode_strap_out = (state_reg == pu_run) && ref_run_reg[0] && ref_clock_zero_src;

  // shared pin steering; select held low and bus lines idle high until the strap is known
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_select_reg <= 2'h0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else if (state_reg == pu_run && strap_reg == strap_sel_pins) begin
      cfg_select_reg <= {cfg_select_bit_one_pin, cfg_select_bit_zero_pin};
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else if (state_reg == pu_run) begin
      cfg_select_reg <= 2'h0;
      scl_reg <= cfg_select_bit_zero_pin;
      sda_reg <= cfg_select_bit_one_pin;
    end
  end
  // data line is open-drain and only pulled in bus mode
  assign cfg_select_bit_one_out = 1'b0;
  assign cfg_select_bit_one_oe = (state_reg == pu_run) && (strap_reg == strap_serial_bus) && serial_data_drive_low;

  diff_gate_map u_gate_map (
    .gate_code(gate_code),
    .pin_enable(gate_map)
  );

  // run enables; stored config can veto any output
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      diff_run_reg <= diff_enable_reset;
      ref_run_reg <= ref_enable_reset;
    end else if (state_reg == pu_run) begin
      diff_run_reg <= gate_map & stored_diff_enable;
      ref_run_reg <= stored_ref_enable;
    end
  end

  assign strap_valid = (state_reg == pu_run);
  assign strap_value = strap_reg;
  assign cfg_select = cfg_select_reg;
  assign serial_clock_line = scl_reg;
  assign serial_data_line = sda_reg;
  assign diff_clock_run = diff_run_reg;
  assign ref_clock_zero_run = ref_run_reg[0];
  assign ref_clock_one_run = ref_run_reg[1];

  // every check waits for the synced reset, so the release edges themselves are not judged
  a_strap_held: assert property (@(posedge clock) disable iff (!rst_n)
    $past(state_reg == pu_run) |-> $stable(strap_reg)) else $error("strap changed after power-up");
  a_strap_caught: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == pu_latch) |=> (strap_reg == $past(strap_pin))) else $error("strap not caught");
  a_ref_drive: assert property (@(posedge clock) disable iff (!rst_n)
    ref_zero_mode_strap_oe == (state_reg == pu_run)) else $error("strap pin drive wrong");
  a_sel_mode: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == pu_run && strap_reg) |=> (cfg_select == $past({cfg_select_bit_one_pin, cfg_select_bit_zero_pin})))
    else $error("select wrong");
  a_bus_no_sel: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg != pu_run || strap_reg == strap_sel_pins) |-> !cfg_select_bit_one_oe) else $error("bus drive early");
  a_pull_low: assert property (@(posedge clock) disable iff (!rst_n)
    (!ref_zero_mode_strap_driven && state_reg == pu_latch) |=> !strap_reg) else $error("pull-down ignored");
  a_gate_map: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == pu_run && stored_diff_enable == 4'hf && gate_code == 2'h0) |=> diff_clock_run == 4'h1)
    else $error("gate map wrong");
  a_gate_all: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == pu_run && stored_diff_enable == 4'hf && gate_code == 2'h3) |=> diff_clock_run == 4'hf)
    else $error("gate all wrong");
  a_stored_off: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == pu_run) |=> ((diff_clock_run & ~$past(stored_diff_enable)) == 4'h0))
    else $error("veto failed");

  // cycles since the synced reset rose, kept apart from the settle counter so a miscount shows
  logic [7:0] since_reset_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      since_reset_reg <= 8'h00;
    end else if (since_reset_reg != 8'hff) begin
      since_reset_reg <= since_reset_reg + 8'h01; // saturates so a long run cannot wrap into a match
    end
  end
  a_settle_time: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == pu_latch) |-> (since_reset_reg == 8'(settle_cycles))) else $error("strap latched at wrong time");

  // power-up steps: settle then latch, and one cycle later the pin becomes the reference output
  sequence s_latch_entry;
    (state_reg == pu_settle) ##1 (state_reg == pu_latch);
  endsequence
  sequence s_run_entry;
    (state_reg == pu_run) && strap_valid && ref_zero_mode_strap_oe;
  endsequence
  a_powerup_order: assert property (@(posedge clock) disable iff (!rst_n)
    s_latch_entry |=> s_run_entry) else $error("power-up order wrong");
  a_ref_run: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == pu_run) |=> ({ref_clock_one_run, ref_clock_zero_run} == $past(stored_ref_enable)))
    else $error("reference run wrong");
  a_bus_mirror: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == pu_run && strap_reg == strap_serial_bus)
    |=> (serial_clock_line == $past(cfg_select_bit_zero_pin) && serial_data_line == $past(cfg_select_bit_one_pin) && cfg_select == 2'h0))
    else $error("bus lines wrong");
endmodule
`default_nettype wire

/* File: verif/board_straps.sv */
// board straps and controller model for the strap, select and enable pins
`timescale 1ns/1ps
`default_nettype none
module board_straps (
  input wire logic clock,
  input wire logic [4:0] level,
  input wire logic [4:0] drive,
  output logic [4:0] pin_in,
  output logic [4:0] pin_driven
);
  logic [4:0] last_reg = 5'h00;
  // released pins toggle so a stale level is never read as driven
  always_ff @(posedge clock) begin
    last_reg <= pin_in;
  end
  // enables driven as a two-bit code of how many pairs run, 00 still runs one pair; released means pull level
  assign pin_driven = drive;
  assign pin_in = (drive & level) | (~drive & ~last_reg);
endmodule
`default_nettype wire

/* File: verif/strap_latch_output_gating_tb.sv */
// self-checking bench for the strap latch and output gating block
`timescale 1ns/1ps
`default_nettype none
module strap_latch_output_gating_tb;
  import clkgen_ctrl_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] level = 5'h00, drive = 5'h00, pin_in, pin_driven;
  logic sdl = 1'b0, src = 1'b0;
  logic [3:0] sde = 4'hf, run;
  logic [1:0] sre = 2'h3, cfg_select;
  logic strap_value, strap_valid, scl, sda, oe0, diff_clock_pair_zero, diff_clock_pair_one, oe1, r0, r1;
  int error_cnt = 0, comparisons = 0, code, wait_cnt;
  logic strap_exp;
  // pins: 0 strap, 1..2 selects (pull-down), 3..4 enables (pull-up)
  board_straps board_straps_inst (.clock(clock), .level(level), .drive(drive), .pin_in(pin_in),
    .pin_driven(pin_driven));
  strap_latch_output_gating #(.settle_cycles(strap_settle_cycles)) strap_latch_output_gating_inst (.clock(clock),
    .arst_n(arst_n), .ref_zero_mode_strap_in(pin_in[0]), .ref_zero_mode_strap_driven(pin_driven[0]),
    .ref_zero_mode_strap_out(diff_clock_pair_zero), .ref_zero_mode_strap_oe(oe0), .cfg_select_bit_zero_in(pin_in[1]),
    .cfg_select_bit_zero_driven(pin_driven[1]), .cfg_select_bit_one_in(pin_in[2]),
    .cfg_select_bit_one_driven(pin_driven[2]), .serial_data_drive_low(sdl), .cfg_select_bit_one_out(diff_clock_pair_one),
    .cfg_select_bit_one_oe(oe1), .output_gate_low_bit(pin_in[3]), .output_gate_low_bit_driven(pin_driven[3]),
    .output_gate_high_bit(pin_in[4]), .output_gate_high_bit_driven(pin_driven[4]),
    .stored_diff_enable(sde), .stored_ref_enable(sre), .ref_clock_zero_src(src), .strap_valid(strap_valid),
    .strap_value(strap_value), .cfg_select(cfg_select), .serial_clock_line(scl), .serial_data_line(sda),
    .diff_clock_run(run), .ref_clock_zero_run(r0), .ref_clock_one_run(r1));
  always #2 clock = ~clock;
  // level the block should read on a pin after its pull
  function automatic logic lvl(int i);
    return drive[i] ? level[i] : (i > 2);
  endfunction
  task automatic check(logic [7:0] got, logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one compare per kind of result: strap latch, shared pins, output run enables
  task automatic check_strap(logic [7:0] got, logic [7:0] exp);
    check(got, exp);
  endtask
  task automatic check_pins(logic [7:0] got, logic [7:0] exp);
    check(got, exp);
  endtask
  task automatic check_run(logic [7:0] got, logic [7:0] exp);
    check(got, exp);
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog well past three power-ups of some 144 cycles each
  initial begin
    #20us;
    error_cnt++;
    stop_test();
  end
  initial begin
    void'($urandom(86));
    for (int p = 0; p < 3; p++) begin
      // power-up with strap high, low, then left to its pull-down; later ones reset in mid-run
      if (p > 0) @(posedge clock);
      arst_n <= 1'b0;
      level <= {4'h0, p == 0};
      drive <= {4'h0, p != 2};
      strap_exp = (p == 0);
      repeat (10) @(posedge clock);
      check_strap(8'({strap_valid, strap_value, oe0}), 8'h00);
      check_pins(8'({cfg_select, scl, sda, oe1}), 8'h06);
      check_run(8'({run, r1, r0}), 8'h00);
      arst_n <= 1'b1;
      for (wait_cnt = 0; wait_cnt < 40 && strap_valid !== 1'b1; wait_cnt++) @(negedge clock);
      // release edge, two sync edges, the settle span and the latch cycle
      check_strap(8'(wait_cnt), 8'(strap_settle_cycles + 4));
      for (int k = 0; k < 40; k++) begin
        // strap pin keeps moving after the latch and must be ignored
        @(posedge clock);
        level <= 5'($urandom);
        drive <= 5'($urandom);
        sdl <= 1'($urandom);
        src <= 1'($urandom);
        sde <= 4'($urandom);
        sre <= 2'($urandom);
        repeat (2) @(posedge clock);
        @(negedge clock);
        code = int'({lvl(4), lvl(3)});
        check_strap(8'(strap_value), 8'(strap_exp));
        check_strap(8'({strap_valid, oe0, diff_clock_pair_zero}), 8'({2'b11, src & sre[0]}));
        check_pins(8'(cfg_select), strap_exp ? 8'({lvl(2), lvl(1)}) : 8'h00);
        check_pins(8'(scl), strap_exp ? 8'h01 : 8'(lvl(1)));
        if (!sdl) check_pins(8'(sda), strap_exp ? 8'h01 : 8'(lvl(2)));
        check_pins(8'({oe1, diff_clock_pair_one}), 8'({!strap_exp && sdl, 1'b0}));
        check_run(8'(run), 8'(((1 << (code + 1)) - 1) & sde));
        check_run(8'({r1, r0}), 8'(sre));
      end
    end
    stop_test();
  end
endmodule
`default_nettype wire
